// file: logic/arla_pkg.sv
`default_nettype none
package arla_pkg;
    // register byte addresses (8-bit data port, one byte per address)
    localparam logic [7:0] ADDR_RESULT_INDEX    = 8'h20;
    localparam logic [7:0] ADDR_RBP_HIGH        = 8'h21;
    localparam logic [7:0] ADDR_RBP_MID         = 8'h22;
    localparam logic [7:0] ADDR_RBP_LOW         = 8'h23;
    localparam logic [7:0] ADDR_OFFSET_FIRST    = 8'h24;
    localparam logic [7:0] ADDR_OFFSET_SECOND   = 8'h25;
    localparam logic [7:0] ADDR_CONTROL         = 8'h26;
    localparam logic [7:0] ADDR_STATUS          = 8'h27;
    // control register fields
    localparam int CTL_ENABLE_BIT  = 0;
    localparam int CTL_SPECIAL_BIT = 1;
    localparam int CTL_BMODE_BIT   = 2;
    localparam int CTL_NEWLIST_BIT = 3;
    // widths
    localparam int IDX_W  = 6;
    localparam int OFF_W  = 7;
    localparam int ADDR_W = 24;
    // reset values and the fixed first offset value
    localparam logic [7:0]  CTL_RESET    = 8'h00;
    localparam logic [17:0] RBP_RESET    = 18'h00000;
    localparam logic [6:0]  OFF1_RESET   = 7'h00;
    localparam logic [6:0]  OFF0_VALUE   = 7'h00;
    // result objects are 16 bit: one index unit is two bytes
    localparam int RES_SHIFT = 1;
    // command objects are 32 bit: one unit is four bytes
    localparam int CMD_SHIFT = 2;
endpackage
`default_nettype wire

// file: logic/arla_buf2.sv
`default_nettype none
module arla_buf2 #(
    parameter int WIDTH = 40
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    // two entries keep full throughput while still registering ready
    logic [WIDTH-1:0] mem_r [2];
    logic [WIDTH-1:0] mem_nxt [2];
    logic             wp_r;
    logic             wp_nxt;
    logic             rp_r;
    logic             rp_nxt;
    logic [1:0]       cnt_r;
    logic [1:0]       cnt_nxt;
    logic             push;
    logic             pop;

    always_comb
    begin
        push = in_valid && (cnt_r != 2'h2);
        pop = out_valid && out_ready;
        mem_nxt = mem_r;
        if (push)
        begin
            mem_nxt[wp_r] = in_data;
        end
        wp_nxt = push ? ~wp_r : wp_r;
        rp_nxt = pop ? ~rp_r : rp_r;
        cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_r <= 2'h0;
            mem_r[0] <= '0;
            mem_r[1] <= '0;
        end
        else
        begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            mem_r <= mem_nxt;
        end
    end

    assign in_ready = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data = mem_r[rp_r];

    no_overflow_a: assert property (@(posedge mclk) disable iff (rst)
        cnt_r != 2'h3) else $error("buffer count beyond two");
endmodule
`default_nettype wire

// file: logic/arla_core.sv
// The address-and-strobe port is this design's own decision.
`default_nettype none
// Behaviour
// - read-only six-bit result index, counted in 16-bit samples
// - base pointer bits 19..2 writable only when disabled or special access
// - base pointer is the system RAM base of the result lists
// - first offset register is read only; writes do nothing
// - second offset writable only when disabled or special access
// - seven-bit second offset serves both second command and result lists
// - offsets scale by object size: 16-bit results, 32-bit commands
// - result address is base plus active offset plus result index
// - buffer mode picks single or alternating double result lists
module arla_core (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic [23:0] command_base,
    input  wire logic [5:0]  command_index,
    output logic      [23:0] command_fetch_addr,
    input  wire logic        result_valid,
    output logic             result_ready,
    input  wire logic [15:0] result_data,
    input  wire logic        list_end,
    output logic             store_valid,
    input  wire logic        store_ready,
    output logic      [23:0] store_addr,
    output logic      [15:0] store_data
);
    logic [7:0]  ctl_r;
    logic [7:0]  ctl_nxt;
    logic [17:0] rbp_r;
    logic [17:0] rbp_nxt;
    logic [6:0]  off1_r;
    logic [6:0]  off1_nxt;
    logic [5:0]  idx_r;
    logic [5:0]  idx_nxt;
    logic        sel_r;
    logic        sel_nxt;
    logic [7:0]  rdata_r;
    logic [7:0]  rdata_nxt;
    logic        unlocked;
    logic        bmode;
    logic [6:0]  active_off;
    logic [23:0] base_addr;
    logic [23:0] res_addr;
    logic        take;
    logic        newlist;
    logic [39:0] buf_out;

    assign unlocked = !ctl_r[arla_pkg::CTL_ENABLE_BIT] || ctl_r[arla_pkg::CTL_SPECIAL_BIT];
    assign bmode = ctl_r[arla_pkg::CTL_BMODE_BIT];
    // single mode forces the first list
    assign active_off = (bmode && sel_r) ? off1_r : arla_pkg::OFF0_VALUE;
    assign base_addr = {4'h0, rbp_r, 2'h0};
    // sum in 16-bit units converted to bytes
    assign res_addr = base_addr
        + ({17'h00000, active_off} << arla_pkg::RES_SHIFT)
        + ({18'h00000, idx_r} << arla_pkg::RES_SHIFT);
    assign command_fetch_addr = command_base
        + ({17'h00000, active_off} << arla_pkg::CMD_SHIFT)
        + ({18'h00000, command_index} << arla_pkg::CMD_SHIFT);
    assign take = result_valid && result_ready;
    assign newlist = reg_wr && (reg_addr == arla_pkg::ADDR_CONTROL)
        && reg_wdata[arla_pkg::CTL_NEWLIST_BIT];

    always_comb
    begin
        ctl_nxt = ctl_r;
        rbp_nxt = rbp_r;
        off1_nxt = off1_r;
        idx_nxt = idx_r;
        sel_nxt = sel_r;
        rdata_nxt = 8'h00;
        if (reg_wr)
        begin
            unique case (reg_addr)
                arla_pkg::ADDR_CONTROL:
                    ctl_nxt = {5'h00, reg_wdata[2:0]};
                arla_pkg::ADDR_RBP_HIGH:
                    if (unlocked)
                    begin
                        rbp_nxt[17:14] = reg_wdata[3:0];
                    end
                arla_pkg::ADDR_RBP_MID:
                    if (unlocked)
                    begin
                        rbp_nxt[13:6] = reg_wdata;
                    end
                arla_pkg::ADDR_RBP_LOW:
                    if (unlocked)
                    begin
                        rbp_nxt[5:0] = reg_wdata[7:2];
                    end
                arla_pkg::ADDR_OFFSET_SECOND:
                    if (unlocked)
                    begin
                        off1_nxt = reg_wdata[6:0];
                    end
                // the first offset and the index ignore writes
                default:
                    ctl_nxt = ctl_r;
            endcase
        end
        // a new list restarts the index; a store in the same cycle uses the old index and does not advance it
        if (newlist || (take && list_end))
        begin
            idx_nxt = 6'h00;
            if (bmode && take && list_end)
            begin
                sel_nxt = ~sel_r;
            end
            if (!bmode)
            begin
                sel_nxt = 1'b0;
            end
        end
        else if (take)
        begin
            idx_nxt = idx_r + 6'h01;
        end
        if (reg_rd)
        begin
            unique case (reg_addr)
                arla_pkg::ADDR_RESULT_INDEX:
                    rdata_nxt = {2'h0, idx_r};
                arla_pkg::ADDR_RBP_HIGH:
                    rdata_nxt = {4'h0, rbp_r[17:14]};
                arla_pkg::ADDR_RBP_MID:
                    rdata_nxt = rbp_r[13:6];
                arla_pkg::ADDR_RBP_LOW:
                    rdata_nxt = {rbp_r[5:0], 2'h0};
                arla_pkg::ADDR_OFFSET_FIRST:
                    rdata_nxt = {1'b0, arla_pkg::OFF0_VALUE};
                arla_pkg::ADDR_OFFSET_SECOND:
                    rdata_nxt = {1'b0, off1_r};
                arla_pkg::ADDR_CONTROL:
                    rdata_nxt = ctl_r;
                arla_pkg::ADDR_STATUS:
                    rdata_nxt = {6'h00, store_valid, sel_r};
                default:
                    rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ctl_r <= arla_pkg::CTL_RESET;
            rbp_r <= arla_pkg::RBP_RESET;
            off1_r <= arla_pkg::OFF1_RESET;
            idx_r <= 6'h00;
            sel_r <= 1'b0;
            rdata_r <= 8'h00;
        end
        else
        begin
            ctl_r <= ctl_nxt;
            rbp_r <= rbp_nxt;
            off1_r <= off1_nxt;
            idx_r <= idx_nxt;
            sel_r <= sel_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // the buffer absorbs a bus stall so no result is dropped
    arla_buf2 #(
        .WIDTH (40)
    ) u_buf (
        .mclk      (mclk),
        .rst       (rst),
        .in_valid  (result_valid),
        .in_ready  (result_ready),
        .in_data   ({res_addr, result_data}),
        .out_valid (store_valid),
        .out_ready (store_ready),
        .out_data  (buf_out)
    );
    assign store_addr = buf_out[39:16];
    assign store_data = buf_out[15:0];

    sequence locked_write_s;
        reg_wr && !unlocked && (reg_addr == arla_pkg::ADDR_OFFSET_SECOND);
    endsequence

    locked_offset_a: assert property (@(posedge mclk) disable iff (rst)
        locked_write_s |=> $stable(off1_r)) else $error("locked offset changed");
    locked_base_a: assert property (@(posedge mclk) disable iff (rst)
        (reg_wr && !unlocked) |=> $stable(rbp_r)) else $error("locked base changed");
    open_offset_a: assert property (@(posedge mclk) disable iff (rst)
        (reg_wr && unlocked && reg_addr == arla_pkg::ADDR_OFFSET_SECOND)
        |=> off1_r == $past(reg_wdata[6:0])) else $error("offset write lost");
    index_step_a: assert property (@(posedge mclk) disable iff (rst)
        (take && !list_end && !newlist) |=> idx_r == $past(idx_r) + 6'h01)
        else $error("index did not advance");
    index_clear_a: assert property (@(posedge mclk) disable iff (rst)
        newlist |=> idx_r == 6'h00) else $error("index not cleared");
    index_read_a: assert property (@(posedge mclk) disable iff (rst)
        (reg_rd && reg_addr == arla_pkg::ADDR_RESULT_INDEX)
        |=> reg_rdata == {2'h0, $past(idx_r)}) else $error("index read wrong");
    first_off_a: assert property (@(posedge mclk) disable iff (rst)
        (reg_rd && reg_addr == arla_pkg::ADDR_OFFSET_FIRST) |=> reg_rdata == 8'h00)
        else $error("first offset not constant");
    single_mode_a: assert property (@(posedge mclk) disable iff (rst)
        (!bmode && take) |-> res_addr == base_addr + {17'h00000, idx_r, 1'b0})
        else $error("single mode address wrong");
    swap_a: assert property (@(posedge mclk) disable iff (rst)
        (bmode && take && list_end && !newlist) |=> sel_r != $past(sel_r))
        else $error("double mode did not swap");

    sequence empty_take_s;
        take && !store_valid;
    endsequence

    sequence store_shows_s;
        store_valid && (store_addr == $past(res_addr)) && (store_data == $past(result_data));
    endsequence

    sequence store_stalled_s;
        store_valid && !store_ready;
    endsequence

    // an idle buffer shows the accepted result and its address one cycle later
    buffer_path_a: assert property (@(posedge mclk) disable iff (rst)
        empty_take_s |=> store_shows_s) else $error("stored word or address wrong");
    // a stalled memory must see the same word until it takes it
    store_hold_a: assert property (@(posedge mclk) disable iff (rst)
        store_stalled_s |=> store_valid && $stable(store_addr) && $stable(store_data))
        else $error("stalled store changed");
    full_refuse_a: assert property (@(posedge mclk) disable iff (rst)
        !result_ready |-> store_valid) else $error("refused while buffer empty");
    index_hold_a: assert property (@(posedge mclk) disable iff (rst)
        (!take && !newlist) |=> $stable(idx_r)) else $error("index moved while idle");
    index_write_a: assert property (@(posedge mclk) disable iff (rst)
        (reg_wr && reg_addr == arla_pkg::ADDR_RESULT_INDEX && !take) |=> $stable(idx_r))
        else $error("index took a write");
    open_base_a: assert property (@(posedge mclk) disable iff (rst)
        (reg_wr && unlocked && reg_addr == arla_pkg::ADDR_RBP_MID)
        |=> rbp_r[13:6] == $past(reg_wdata)) else $error("base write lost");
    offset_hold_a: assert property (@(posedge mclk) disable iff (rst)
        !(reg_wr && reg_addr == arla_pkg::ADDR_OFFSET_SECOND) |=> $stable(off1_r))
        else $error("offset changed without a write");
    single_sel_a: assert property (@(posedge mclk) disable iff (rst)
        (!bmode && take && list_end) |=> !sel_r) else $error("single mode left first list");
    sel_hold_a: assert property (@(posedge mclk) disable iff (rst)
        (bmode && !(take && list_end)) |=> $stable(sel_r)) else $error("list swapped early");
    status_read_a: assert property (@(posedge mclk) disable iff (rst)
        (reg_rd && reg_addr == arla_pkg::ADDR_STATUS)
        |=> reg_rdata == {6'h00, $past(store_valid), $past(sel_r)})
        else $error("status read wrong");
    // read data stand only in the cycle after the strobe
    read_idle_a: assert property (@(posedge mclk) disable iff (rst)
        !reg_rd |=> reg_rdata == 8'h00) else $error("read data outside its cycle");
endmodule
`default_nettype wire

// file: tb/arla_ram_model.sv
`default_nettype none
module arla_ram_model (
    input  wire logic        mclk,
    input  wire logic        stall,
    input  wire logic        store_valid,
    output logic             store_ready,
    input  wire logic [23:0] store_addr,
    input  wire logic [15:0] store_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] addr_q[$];
    logic [15:0] data_q[$];
    // a stalled memory holds off the store; the block must keep the word
    assign store_ready = ~stall;
    always @(posedge mclk)
    begin
        if (store_valid === 1'b1 && store_ready === 1'b1)
        begin
            addr_q.push_back(store_addr);
            data_q.push_back(store_data);
        end
    end
endmodule
`default_nettype wire

// file: tb/adc_result_list_addressing_test.sv
`default_nettype none
module adc_result_list_addressing_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic [23:0] command_base = 24'h001000;
    logic [5:0]  command_index = 6'h03;
    logic [23:0] command_fetch_addr;
    logic        result_valid = 1'b0;
    logic        result_ready;
    logic [15:0] result_data = 16'h0000;
    logic        list_end = 1'b0;
    logic        store_valid;
    logic        store_ready;
    logic [23:0] store_addr;
    logic [15:0] store_data;
    logic        stall = 1'b0;
    logic [7:0]  v;
    int          n_errors = 0;
    int          num_checks = 0;
    int          cycles = 0;
    logic [7:0]  ra[7] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h30};
    logic [7:0]  wd[6] = '{8'h11, 8'hFF, 8'h12, 8'hFF, 8'h55, 8'h7F};
    logic [7:0]  rx[6] = '{8'h00, 8'h0F, 8'h12, 8'hFC, 8'h00, 8'h7F};
    logic [23:0] ea[6] = '{24'h0F12FC, 24'h0F12FE, 24'h0F1300, 24'h0F12FC, 24'h0F131C,
                           24'h0F131C};
    always #12.5 mclk = ~mclk;
    arla_core i_dut (
        .mclk               (mclk),
        .rst                (rst),
        .reg_addr           (reg_addr),
        .reg_wdata          (reg_wdata),
        .reg_wr             (reg_wr),
        .reg_rd             (reg_rd),
        .reg_rdata          (reg_rdata),
        .command_base       (command_base),
        .command_index      (command_index),
        .command_fetch_addr (command_fetch_addr),
        .result_valid       (result_valid),
        .result_ready       (result_ready),
        .result_data        (result_data),
        .list_end           (list_end),
        .store_valid        (store_valid),
        .store_ready        (store_ready),
        .store_addr         (store_addr),
        .store_data         (store_data)
    );
    arla_ram_model i_ram (
        .mclk        (mclk),
        .stall       (stall),
        .store_valid (store_valid),
        .store_ready (store_ready),
        .store_addr  (store_addr),
        .store_data  (store_data)
    );
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        // one idle edge keeps the strobe from being lowered and raised in one step
        @(posedge mclk);
    endtask
    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        check($sformatf("reg %h", a), {16'h0000, reg_rdata}, {16'h0000, exp});
        @(posedge mclk);
    endtask
    task automatic send(input logic [15:0] d, input logic last);
        int t;
        t = 0;
        result_valid <= 1'b1;
        result_data <= d;
        list_end <= last;
        @(posedge mclk);
        while (result_ready !== 1'b1 && t < 50)
        begin
            t++;
            @(posedge mclk);
        end
        check("result taken", {23'h000000, result_ready}, 24'h000001);
        result_valid <= 1'b0;
        list_end <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ceiling well above the hundred or so cycles the tests need
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            print_verdict();
        end
    end
    initial
    begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        foreach (ra[i]) rd(ra[i], 8'h00);
        $display("test reset values done");
        foreach (wd[i]) wr(ra[i], wd[i]);
        foreach (wd[i]) rd(ra[i], rx[i]);
        $display("test disabled writes done");
        wr(8'h26, 8'h01);
        wr(8'h22, 8'h34);
        wr(8'h25, 8'h11);
        rd(8'h22, 8'h12);
        rd(8'h25, 8'h7F);
        wr(8'h26, 8'h03);
        wr(8'h25, 8'h10);
        rd(8'h25, 8'h10);
        wr(8'h26, 8'h01);
        $display("test enabled writes done");
        stall <= 1'b1;
        send(16'hA001, 1'b0);
        send(16'hA002, 1'b0);
        check("ready full", {23'h0, result_ready}, 24'h0);
        rd(8'h20, 8'h02);
        stall <= 1'b0;
        send(16'hA003, 1'b1);
        repeat (4) @(posedge mclk);
        rd(8'h20, 8'h00);
        $display("test single list done");
        wr(8'h26, 8'h05);
        send(16'hA004, 1'b1);
        send(16'hA005, 1'b0);
        repeat (4) @(posedge mclk);
        rd(8'h20, 8'h01);
        check("fetch", command_fetch_addr, 24'h00104C);
        wr(8'h26, 8'h0D);
        rd(8'h20, 8'h00);
        rd(8'h26, 8'h05);
        send(16'hA006, 1'b0);
        repeat (4) @(posedge mclk);
        rd(8'h27, 8'h01);
        $display("test double list done");
        check("stores", i_ram.addr_q.size(), 24'h6);
        foreach (ea[i]) check("addr", i_ram.addr_q[i], ea[i]);
        foreach (ea[i]) check("data", i_ram.data_q[i], 24'hA001 + i);
        $display("test store contents done");
        print_verdict();
    end
endmodule
`default_nettype wire
